// *** audio_dsp_consts.vh ***
// constants of the audio processor register bank
// assumes 24-bit words and 16-bit word addresses from the serial host engine
`ifndef AUDIO_DSP_CONSTS_VH
`define AUDIO_DSP_CONSTS_VH

// ----------------------------------------------------------------
// addresses, reset values, masks, fields and codes
// ----------------------------------------------------------------
`define ADDR_RIGHT_LOW  16'h0ff2
`define ADDR_RIGHT_HIGH 16'h0ff3
`define ADDR_LEFT_LOW   16'h0ff4
`define ADDR_LEFT_HIGH  16'h0ff5
`define ADDR_SELECTOR   16'h0ffb
`define ADDR_GEN_CTRL   16'h602f
`define GEN_CTRL_RESET  24'h00_50c6
`define GEN_CTRL_WMASK  24'h3c_f97e
`define SELECTOR_RESET  24'h00_10db
`define SELECTOR_WMASK  24'h1f_dfff
`define WORD_ZERO       24'h00_0000
`define STATUS_PAD      4'h0
`define GC_DIV_HI       5
`define GC_DIV_LO       1
`define GC_TURBO        6
`define GC_HOLD         8
`define GC_SEL_HI       13
`define GC_SEL_LO       11
`define GC_LOOP_HI      15
`define GC_LOOP_LO      14
`define GC_CONV_HI      19
`define GC_CONV_LO      18
`define GC_SYSTEM_CLOCK_OUTPUT_PIN_OFF   20
`define GC_FIXED_256    21
`define SR_FMT14_HI     2
`define SR_FMT14_LO     0
`define SR_FMT2_HI      5
`define SR_FMT2_LO      3
`define SR_FMT3_HI      8
`define SR_FMT3_LO      6
`define SR_FMTO_HI      11
`define SR_FMTO_LO      9
`define SR_OUT_EN       12
`define SR_MAIN_HI      17
`define SR_MAIN_LO      14
`define SR_OPT1         18
`define SR_OPT2         19
`define SR_STAT_SRC     20
`define MAIN_SERIAL1    4'h0
`define MAIN_SERIAL2    4'h5
`define MAIN_SERIAL3    4'ha
`define CONV_WORD_PLL   2'h0
`define CONV_EXT_512    2'h1
`define CONV_EXT_256    2'h3
`define FMT_IN_I2S      3'h3
`define FMT_OUT_I2S     3'h0
`define FMT_LSB16       3'h4
`define FMT_LSB18       3'h5
`define FMT_LSB20       3'h6
`define FMT_LSB24       3'h7
`define LEN_NONE        5'h00
`define LEN_16          5'h10
`define LEN_18          5'h12
`define LEN_20          5'h14
`define LEN_24          5'h18
`define STATUS_HALF     20

`endif

// *** serial_format_decode.v ***
// registered decoder of a 3-bit serial data format code
// assumes the code comes from a register on the same clock
`default_nettype none
`include "audio_dsp_consts.vh"

module serial_format_decode #(
    parameter [2:0] I2S_CODE = `FMT_IN_I2S
) (
    input  wire       ref_clk_in,
    input  wire       reset_in,
    input  wire       clk_en_in,
    input  wire [2:0] code_in,
    output reg        i2s_out,
    output reg  [4:0] lsb_width_out,
    output reg        bad_code_out
);

    reg       i2s_nxt;
    reg [4:0] width_nxt;
    reg       bad_nxt;

    always @* begin
        i2s_nxt   = 1'b0;
        width_nxt = `LEN_NONE;
        bad_nxt   = 1'b0;
        if (code_in == I2S_CODE) begin
            i2s_nxt = 1'b1;
        end else if (code_in == `FMT_LSB16) begin
            width_nxt = `LEN_16;
        end else if (code_in == `FMT_LSB18) begin
            width_nxt = `LEN_18;
        end else if (code_in == `FMT_LSB20) begin
            width_nxt = `LEN_20;
        end else if (code_in == `FMT_LSB24) begin
            width_nxt = `LEN_24;
        end else begin
            bad_nxt = 1'b1;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            i2s_out       <= 1'b0;
            lsb_width_out <= `LEN_NONE;
            bad_code_out  <= 1'b0;
        end else if (clk_en_in) begin
            i2s_out       <= i2s_nxt;
            lsb_width_out <= width_nxt;
            bad_code_out  <= bad_nxt;
        end
    end

endmodule // serial_format_decode
`default_nettype wire

// *** status_capture.v ***
// captures one channel's status word from one of two optical receivers
// assumes receivers run on the same clock and pulse a strobe with a full word
`default_nettype none
`include "audio_dsp_consts.vh"

module status_capture #(
    parameter WIDTH = 40
) (
    input  wire             ref_clk_in,
    input  wire             reset_in,
    input  wire             clk_en_in,
    input  wire             source_sel_in,
    input  wire [WIDTH-1:0] first_word_in,
    input  wire             first_strobe_in,
    input  wire [WIDTH-1:0] second_word_in,
    input  wire             second_strobe_in,
    output reg  [WIDTH-1:0] word_out
);

    wire             take_w = source_sel_in ? second_strobe_in : first_strobe_in;
    wire [WIDTH-1:0] data_w = source_sel_in ? second_word_in : first_word_in;

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            word_out <= {WIDTH{1'b0}};
        end else if (clk_en_in && take_w) begin
            word_out <= data_w;
        end
    end

endmodule // status_capture
`default_nettype wire

// *** audio_dsp_control_registers.v ***
// control and status register bank of the audio signal processor
// assumes a serial host engine on the same clock presents whole 24-bit words
// assumes the external clock activity flag arrives from a pin, unsynchronised
`default_nettype none
`include "audio_dsp_consts.vh"

// Overview of operation
// - clock divisor bits 5..1 reset 00011, doubling bit 6 reset 1
// - bit 8 holds processor program counter in reset while set, reset 0
// - bits 13..11 pick the system clock output multiple, reset 010
// - bits 15..14 pick word-rate pll input range, reset 01
// - bits 19..18 pick converter clock: pll if pin idle, 512x, 256x
// - bit 20 set disables system clock output pin, reset 0
// - bit 21 set forces fixed 256x system clock, else bits 13..11
// - right status word shown as low and high 20-bit halves, reset zero
// - left status word shown as low and high 20-bit halves, reset zero
// - selector bit 20 picks status source: 1 second optical, 0 first
// - selector bits 2..0 format of serial inputs one and four, reset 011
// - selector bits 5..3 format of serial input two, reset 011
// - selector bits 8..6 format of serial input three, reset 011
// - selector bits 11..9 common format of serial outputs, reset 000
// - selector bit 12 enables the digital serial outputs
// - bits 17..14 main source 0000, 0101, 1010; other codes never written
// - bit 18 routes first optical input instead of serial input two
// - bit 19 routes second optical input instead of serial input three
// - input codes: 011 i2s, 100..111 lsb-justified 16, 18, 20, 24
// - output codes: 000 i2s, 100..111 lsb-justified 16, 18, 20, 24
// - every write is acknowledged; reserved data dropped, reserved bits read their reset values, unmapped reads zero
module audio_dsp_control_registers #(
    parameter STATUS_WIDTH = 40
) (
    input  wire                    ref_clk_in,
    input  wire                    reset_in,
    input  wire                    clk_en_in,
    // word access from the serial host engine
    input  wire [15:0]             addr_in,
    input  wire                    write_strobe_in,
    input  wire [23:0]             write_data_in,
    input  wire                    read_strobe_in,
    output reg                     write_ack_out,
    output reg                     read_valid_out,
    output reg  [23:0]             read_data_out,
    // optical receiver status words
    input  wire [STATUS_WIDTH-1:0] opt1_left_status_in,
    input  wire [STATUS_WIDTH-1:0] opt1_right_status_in,
    input  wire                    opt1_status_strobe_in,
    input  wire [STATUS_WIDTH-1:0] opt2_left_status_in,
    input  wire [STATUS_WIDTH-1:0] opt2_right_status_in,
    input  wire                    opt2_status_strobe_in,
    // external converter clock pin activity
    input  wire                    ext_clock_active_in,
    // processor clock controls
    output reg  [4:0]              pll_divisor_out,
    output reg                     pll_double_out,
    output reg                     core_counter_hold_out,
    output reg  [1:0]              word_rate_pll_range_out,
    // system clock output pin
    output reg                     system_clock_output_pin_en_out,
    output reg                     fixed_rate_clock_choice_out,
    output reg  [2:0]              system_clock_multiple_out,
    // output converter clock
    output reg                     converter_from_pll_out,
    output reg                     converter_from_ext512_out,
    output reg                     converter_from_ext256_out,
    // routing
    output reg                     serial_outputs_enable_out,
    output reg                     main_from_serial1_out,
    output reg                     main_from_serial2_out,
    output reg                     main_from_optical1_out,
    output reg                     main_from_serial3_out,
    output reg                     main_from_optical2_out,
    output reg                     first_optical_route_out,
    output reg                     second_optical_route_out,
    // decoded serial formats
    output wire                    in14_i2s_out,
    output wire [4:0]              in14_lsb_width_out,
    output wire                    in2_i2s_out,
    output wire [4:0]              in2_lsb_width_out,
    output wire                    in3_i2s_out,
    output wire [4:0]              in3_lsb_width_out,
    output wire                    out_i2s_out,
    output wire [4:0]              out_lsb_width_out,
    output wire [3:0]              bad_format_out
);

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    reg ext_active_meta_r;
    reg ext_active_r;

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            ext_active_meta_r <= 1'b0;
            ext_active_r      <= 1'b0;
        end else if (clk_en_in) begin
            ext_active_meta_r <= ext_clock_active_in;
            ext_active_r      <= ext_active_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    reg  [23:0] gen_ctrl_r;
    reg  [23:0] gen_ctrl_nxt;
    reg  [23:0] selector_r;
    reg  [23:0] selector_nxt;
    reg  [3:0]  main_code_w;
    wire [STATUS_WIDTH-1:0] left_word_w;
    wire [STATUS_WIDTH-1:0] right_word_w;

    // reserved bits keep their defaults, so their data is dropped
    always @* begin
        gen_ctrl_nxt = gen_ctrl_r;
        selector_nxt = selector_r;
        main_code_w  = write_data_in[`SR_MAIN_HI:`SR_MAIN_LO];
        if (write_strobe_in && addr_in == `ADDR_GEN_CTRL) begin
            gen_ctrl_nxt = (write_data_in & `GEN_CTRL_WMASK)
                         | (`GEN_CTRL_RESET & ~`GEN_CTRL_WMASK);
        end else if (write_strobe_in && addr_in == `ADDR_SELECTOR) begin
            selector_nxt = (write_data_in & `SELECTOR_WMASK)
                         | (`SELECTOR_RESET & ~`SELECTOR_WMASK);
            // a reserved source code leaves the previous source in place
            if (main_code_w != `MAIN_SERIAL1 && main_code_w != `MAIN_SERIAL2
                && main_code_w != `MAIN_SERIAL3) begin
                selector_nxt[`SR_MAIN_HI:`SR_MAIN_LO] =
                    selector_r[`SR_MAIN_HI:`SR_MAIN_LO];
            end
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            gen_ctrl_r <= `GEN_CTRL_RESET;
            selector_r <= `SELECTOR_RESET;
        end else if (clk_en_in) begin
            gen_ctrl_r <= gen_ctrl_nxt;
            selector_r <= selector_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read and write answers
    // ----------------------------------------------------------------
    reg [23:0] read_nxt;

    always @* begin
        if (addr_in == `ADDR_GEN_CTRL) begin
            read_nxt = gen_ctrl_r;
        end else if (addr_in == `ADDR_SELECTOR) begin
            read_nxt = selector_r;
        end else if (addr_in == `ADDR_RIGHT_LOW) begin
            read_nxt = {`STATUS_PAD, right_word_w[`STATUS_HALF-1:0]};
        end else if (addr_in == `ADDR_RIGHT_HIGH) begin
            read_nxt = {`STATUS_PAD, right_word_w[STATUS_WIDTH-1:`STATUS_HALF]};
        end else if (addr_in == `ADDR_LEFT_LOW) begin
            read_nxt = {`STATUS_PAD, left_word_w[`STATUS_HALF-1:0]};
        end else if (addr_in == `ADDR_LEFT_HIGH) begin
            read_nxt = {`STATUS_PAD, left_word_w[STATUS_WIDTH-1:`STATUS_HALF]};
        end else begin
            read_nxt = `WORD_ZERO;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            write_ack_out  <= 1'b0;
            read_valid_out <= 1'b0;
            read_data_out  <= `WORD_ZERO;
        end else if (clk_en_in) begin
            write_ack_out  <= write_strobe_in;
            read_valid_out <= read_strobe_in && !write_strobe_in;
            if (read_strobe_in && !write_strobe_in) begin
                read_data_out <= read_nxt;
            end
        end
    end

    // ----------------------------------------------------------------
    // status capture
    // ----------------------------------------------------------------
    status_capture #(
        .WIDTH            (STATUS_WIDTH)
    ) u_left_capture (
        .ref_clk_in       (ref_clk_in),
        .reset_in         (reset_in),
        .clk_en_in        (clk_en_in),
        .source_sel_in    (selector_r[`SR_STAT_SRC]),
        .first_word_in    (opt1_left_status_in),
        .first_strobe_in  (opt1_status_strobe_in),
        .second_word_in   (opt2_left_status_in),
        .second_strobe_in (opt2_status_strobe_in),
        .word_out         (left_word_w)
    );

    status_capture #(
        .WIDTH            (STATUS_WIDTH)
    ) u_right_capture (
        .ref_clk_in       (ref_clk_in),
        .reset_in         (reset_in),
        .clk_en_in        (clk_en_in),
        .source_sel_in    (selector_r[`SR_STAT_SRC]),
        .first_word_in    (opt1_right_status_in),
        .first_strobe_in  (opt1_status_strobe_in),
        .second_word_in   (opt2_right_status_in),
        .second_strobe_in (opt2_status_strobe_in),
        .word_out         (right_word_w)
    );

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    localparam [23:0] GC_RST = `GEN_CTRL_RESET;
    wire [1:0] conv_w = gen_ctrl_r[`GC_CONV_HI:`GC_CONV_LO];
    wire [3:0] main_w = selector_r[`SR_MAIN_HI:`SR_MAIN_LO];
    wire       opt1_w = selector_r[`SR_OPT1];
    wire       opt2_w = selector_r[`SR_OPT2];

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            pll_divisor_out <= GC_RST[`GC_DIV_HI:`GC_DIV_LO];
            pll_double_out <= GC_RST[`GC_TURBO];
            core_counter_hold_out <= 1'b0;
            word_rate_pll_range_out <= GC_RST[`GC_LOOP_HI:`GC_LOOP_LO];
            system_clock_output_pin_en_out <= 1'b0;
            fixed_rate_clock_choice_out <= 1'b0;
            system_clock_multiple_out <= GC_RST[`GC_SEL_HI:`GC_SEL_LO];
            converter_from_pll_out <= 1'b0;
            converter_from_ext512_out <= 1'b0;
            converter_from_ext256_out <= 1'b0;
            serial_outputs_enable_out <= 1'b0;
            main_from_serial1_out <= 1'b0;
            main_from_serial2_out <= 1'b0;
            main_from_optical1_out <= 1'b0;
            main_from_serial3_out <= 1'b0;
            main_from_optical2_out <= 1'b0;
            first_optical_route_out <= 1'b0;
            second_optical_route_out <= 1'b0;
        end else if (clk_en_in) begin
            pll_divisor_out           <= gen_ctrl_r[`GC_DIV_HI:`GC_DIV_LO];
            pll_double_out            <= gen_ctrl_r[`GC_TURBO];
            core_counter_hold_out     <= gen_ctrl_r[`GC_HOLD];
            word_rate_pll_range_out   <= gen_ctrl_r[`GC_LOOP_HI:`GC_LOOP_LO];
            system_clock_output_pin_en_out <= !gen_ctrl_r[`GC_SYSTEM_CLOCK_OUTPUT_PIN_OFF];
            fixed_rate_clock_choice_out    <= gen_ctrl_r[`GC_FIXED_256];
            system_clock_multiple_out <= gen_ctrl_r[`GC_SEL_HI:`GC_SEL_LO];
            converter_from_pll_out    <= (conv_w == `CONV_WORD_PLL)
                                         && !ext_active_r;
            converter_from_ext512_out <= (conv_w == `CONV_EXT_512);
            converter_from_ext256_out <= (conv_w == `CONV_EXT_256);
            serial_outputs_enable_out <= selector_r[`SR_OUT_EN];
            main_from_serial1_out     <= (main_w == `MAIN_SERIAL1);
            main_from_serial2_out     <= (main_w == `MAIN_SERIAL2) && !opt1_w;
            main_from_optical1_out    <= (main_w == `MAIN_SERIAL2) && opt1_w;
            main_from_serial3_out     <= (main_w == `MAIN_SERIAL3) && !opt2_w;
            main_from_optical2_out    <= (main_w == `MAIN_SERIAL3) && opt2_w;
            first_optical_route_out   <= opt1_w;
            second_optical_route_out  <= opt2_w;
        end
    end

    // ----------------------------------------------------------------
    // serial format decoders
    // ----------------------------------------------------------------
    serial_format_decode #(
        .I2S_CODE      (`FMT_IN_I2S)
    ) u_fmt_in14 (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .clk_en_in     (clk_en_in),
        .code_in       (selector_r[`SR_FMT14_HI:`SR_FMT14_LO]),
        .i2s_out       (in14_i2s_out),
        .lsb_width_out (in14_lsb_width_out),
        .bad_code_out  (bad_format_out[0])
    );

    serial_format_decode #(
        .I2S_CODE      (`FMT_IN_I2S)
    ) u_fmt_in2 (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .clk_en_in     (clk_en_in),
        .code_in       (selector_r[`SR_FMT2_HI:`SR_FMT2_LO]),
        .i2s_out       (in2_i2s_out),
        .lsb_width_out (in2_lsb_width_out),
        .bad_code_out  (bad_format_out[1])
    );

    serial_format_decode #(
        .I2S_CODE      (`FMT_IN_I2S)
    ) u_fmt_in3 (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .clk_en_in     (clk_en_in),
        .code_in       (selector_r[`SR_FMT3_HI:`SR_FMT3_LO]),
        .i2s_out       (in3_i2s_out),
        .lsb_width_out (in3_lsb_width_out),
        .bad_code_out  (bad_format_out[2])
    );

    serial_format_decode #(
        .I2S_CODE      (`FMT_OUT_I2S)
    ) u_fmt_out (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .clk_en_in     (clk_en_in),
        .code_in       (selector_r[`SR_FMTO_HI:`SR_FMTO_LO]),
        .i2s_out       (out_i2s_out),
        .lsb_width_out (out_lsb_width_out),
        .bad_code_out  (bad_format_out[3])
    );

endmodule // audio_dsp_control_registers
`default_nettype wire

// *** optical_source.sv ***
// pair of optical receivers handing 40-bit status words to the bank
// assumes the bench raises fire for one clock per delivered word
`default_nettype none
module optical_source (
    input  wire logic [1:0]  fire_in,
    input  wire logic [39:0] word_in,
    output logic      [39:0] o1_left_out,
    output logic      [39:0] o1_right_out,
    output logic      [39:0] o2_left_out,
    output logic      [39:0] o2_right_out,
    output logic      [1:0]  strobe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // between deliveries each line carries the inverse of what it delivers, never a stale copy
    assign strobe_out   = fire_in;
    assign o1_left_out  = fire_in[0] ? word_in : ~word_in;
    assign o1_right_out = fire_in[0] ? ~word_in : word_in;
    assign o2_left_out  = fire_in[1] ? word_in : ~word_in;
    assign o2_right_out = fire_in[1] ? ~word_in : word_in;
endmodule // optical_source
`default_nettype wire

// *** audio_dsp_control_registers_assertions.sv ***
// port assertions of the audio processor register bank
// assumes binding into every instance of the bank
`default_nettype none
`include "audio_dsp_consts.vh"
module audio_dsp_checker (
    input wire logic        ref_clk_in, reset_in, clk_en_in, write_strobe_in, read_strobe_in,
    input wire logic        write_ack_out, read_valid_out, core_counter_hold_out,
    input wire logic        system_clock_output_pin_en_out, serial_outputs_enable_out,
    input wire logic [15:0] addr_in,
    input wire logic [23:0] write_data_in, read_data_out,
    input wire logic [4:0]  pll_divisor_out
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic gcw = write_strobe_in && clk_en_in && addr_in == `ADDR_GEN_CTRL;
    wire logic srw = write_strobe_in && clk_en_in && addr_in == `ADDR_SELECTOR;
    wire logic rdq = read_strobe_in && !write_strobe_in && clk_en_in;
    wire logic unm = !((addr_in >= `ADDR_RIGHT_LOW && addr_in <= `ADDR_LEFT_HIGH)
                       || addr_in == `ADDR_SELECTOR || addr_in == `ADDR_GEN_CTRL);
    default clocking cb @(posedge ref_clk_in); endclocking
    sequence gc2; gcw ##1 clk_en_in ##1 clk_en_in; endsequence
    default disable iff (reset_in);
    a_write_ack: assert property (write_strobe_in && clk_en_in |=> write_ack_out)
        else $error("write not acknowledged");
    a_ack_cause: assert property (clk_en_in && !write_strobe_in |=> !write_ack_out)
        else $error("acknowledge without write");
    a_read_valid: assert property (rdq |=> read_valid_out)
        else $error("read not answered");
    a_unmapped_zero: assert property (rdq && unm |=> read_data_out == `WORD_ZERO)
        else $error("unmapped read not zero");
    a_div_follow: assert property (gc2 |->
        pll_divisor_out == $past(write_data_in[5:1], 2)) else $error("divisor not taken");
    a_hold_follow: assert property (gc2 |->
        core_counter_hold_out == $past(write_data_in[8], 2)) else $error("hold not taken");
    a_pin_follow: assert property (gc2 |->
        system_clock_output_pin_en_out == !$past(write_data_in[20], 2)) else $error("pin bad");
    a_outen_follow: assert property (srw ##1 clk_en_in ##1 clk_en_in |->
        serial_outputs_enable_out == $past(write_data_in[12], 2)) else $error("out enable bad");
    c_gen_write: cover property (gcw);
    c_sel_write: cover property (srw);
    c_unmapped_read: cover property (rdq && unm);
endmodule // audio_dsp_checker
bind audio_dsp_control_registers audio_dsp_checker chk_u (.*);
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the audio processor register bank
// assumes the bank, its constants header, the checker and the receiver model
`default_nettype none
`include "audio_dsp_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, ext_clock_active_in = 1'b0;
    logic        write_strobe_in = 1'b0, read_strobe_in = 1'b0;
    logic [1:0]  fire_r = 2'h0;
    logic [15:0] addr_in = 16'h0000;
    logic [23:0] write_data_in = `WORD_ZERO, gc = `GEN_CTRL_RESET, sel = `SELECTOR_RESET, d, r;
    logic [39:0] word_r = '0, rw = '0, lw = '0;
    wire logic        write_ack_out, read_valid_out;
    wire logic [1:0]  st;
    wire logic [2:0]  cq;
    wire logic [7:0]  sq;
    wire logic [13:0] gq;
    wire logic [23:0] read_data_out;
    wire logic [27:0] fq;
    wire logic [39:0] o1l, o1r, o2l, o2r;
    integer      seed = 32'h0000_cc4d, n_mismatch = 0, n_checks = 0;
    logic [15:0] amap [7] = '{`ADDR_RIGHT_LOW, `ADDR_RIGHT_HIGH, `ADDR_LEFT_LOW, `ADDR_LEFT_HIGH,
                              `ADDR_SELECTOR, `ADDR_GEN_CTRL, 16'h1234};
    audio_dsp_control_registers dut_u (.*,
        .opt1_left_status_in(o1l), .opt1_right_status_in(o1r), .opt1_status_strobe_in(st[0]),
        .opt2_left_status_in(o2l), .opt2_right_status_in(o2r), .opt2_status_strobe_in(st[1]),
        .pll_divisor_out(gq[13:9]), .pll_double_out(gq[8]), .core_counter_hold_out(gq[7]),
        .word_rate_pll_range_out(gq[6:5]), .system_clock_output_pin_en_out(gq[4]),
        .fixed_rate_clock_choice_out(gq[3]), .system_clock_multiple_out(gq[2:0]),
        .converter_from_pll_out(cq[2]), .converter_from_ext512_out(cq[1]),
        .converter_from_ext256_out(cq[0]), .serial_outputs_enable_out(sq[7]),
        .first_optical_route_out(sq[6]), .second_optical_route_out(sq[5]),
        .main_from_serial1_out(sq[4]), .main_from_serial2_out(sq[3]),
        .main_from_optical1_out(sq[2]), .main_from_serial3_out(sq[1]),
        .main_from_optical2_out(sq[0]), .in14_i2s_out(fq[27]), .in14_lsb_width_out(fq[26:22]),
        .in2_i2s_out(fq[21]), .in2_lsb_width_out(fq[20:16]), .in3_i2s_out(fq[15]),
        .in3_lsb_width_out(fq[14:10]), .out_i2s_out(fq[9]), .out_lsb_width_out(fq[8:4]),
        .bad_format_out(fq[3:0]));
    optical_source src_u (.fire_in(fire_r), .word_in(word_r), .o1_left_out(o1l),
        .o1_right_out(o1r), .o2_left_out(o2l), .o2_right_out(o2r), .strobe_out(st));
    always #2 ref_clk_in = ~ref_clk_in;
    function automatic logic [5:0] fw(input logic [2:0] f, input logic o);
        return {o ? f == `FMT_OUT_I2S : f == `FMT_IN_I2S, f == `FMT_LSB16 ? `LEN_16 :
            f == `FMT_LSB18 ? `LEN_18 : f == `FMT_LSB20 ? `LEN_20 :
            f == `FMT_LSB24 ? `LEN_24 : `LEN_NONE};
    endfunction
    function automatic logic fb(input logic [2:0] f, input logic o);
        return o ? (f != `FMT_OUT_I2S && f < `FMT_LSB16) : f < `FMT_IN_I2S;
    endfunction
    function automatic logic [23:0] rdm(input logic [15:0] a);
        case (a)
            `ADDR_RIGHT_LOW: return {`STATUS_PAD, rw[19:0]};
            `ADDR_RIGHT_HIGH: return {`STATUS_PAD, rw[39:20]};
            `ADDR_LEFT_LOW: return {`STATUS_PAD, lw[19:0]};
            `ADDR_LEFT_HIGH: return {`STATUS_PAD, lw[39:20]};
            `ADDR_SELECTOR: return sel;
            `ADDR_GEN_CTRL: return gc;
            default: return `WORD_ZERO;
        endcase
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [23:0] v);
        logic [23:0] n;
        addr_in <= a;
        write_data_in <= v;
        write_strobe_in <= 1'b1;
        @(posedge ref_clk_in);
        write_strobe_in <= 1'b0;
        #1;
        chk(write_ack_out, 1'b1);
        n = (v & `SELECTOR_WMASK) | (`SELECTOR_RESET & ~`SELECTOR_WMASK);
        if (!(v[17:14] inside {`MAIN_SERIAL1, `MAIN_SERIAL2, `MAIN_SERIAL3})) n[17:14] = sel[17:14];
        if (a == `ADDR_SELECTOR) sel = n;
        if (a == `ADDR_GEN_CTRL) gc = (v & `GEN_CTRL_WMASK) | (`GEN_CTRL_RESET & ~`GEN_CTRL_WMASK);
    endtask
    task automatic rd(input logic [15:0] a);
        addr_in <= a;
        read_strobe_in <= 1'b1;
        @(posedge ref_clk_in);
        read_strobe_in <= 1'b0;
        #1;
        chk({read_valid_out, read_data_out}, {1'b1, rdm(a)});
    endtask
    task automatic out_chk;
        logic [3:0] m;
        m = sel[17:14];
        chk(gq, {gc[5:1], gc[6], gc[8], gc[15:14], !gc[20], gc[21], gc[13:11]});
        chk(cq, {gc[19:18] == `CONV_WORD_PLL && !ext_clock_active_in, gc[19:18] == `CONV_EXT_512,
            gc[19:18] == `CONV_EXT_256});
        chk(sq, {sel[12], sel[18], sel[19], m == 4'h0, m == 4'h5 && !sel[18], m == 4'h5 && sel[18],
            m == 4'ha && !sel[19], m == 4'ha && sel[19]});
        chk(fq, {fw(sel[2:0], 1'b0), fw(sel[5:3], 1'b0), fw(sel[8:6], 1'b0), fw(sel[11:9], 1'b1),
            fb(sel[11:9], 1'b1), fb(sel[8:6], 1'b0), fb(sel[5:3], 1'b0), fb(sel[2:0], 1'b0)});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge ref_clk_in);
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        out_chk;
        for (int k = 0; k < 7; k++) rd(amap[k]);
        for (int i = 0; i < 48; i++) begin
            d = 24'($random(seed));
            r = 24'($random(seed));
            ext_clock_active_in <= d[23];
            if (i < 8) r[11:0] = {4{i[2:0]}};
            if (i % 4 != 3) r[17:14] = i % 4 == 0 ? `MAIN_SERIAL1 : i % 4 == 1 ? `MAIN_SERIAL2 : `MAIN_SERIAL3;
            if (i % 2 == 1) d = (d & `GEN_CTRL_WMASK) | (`GEN_CTRL_RESET & ~`GEN_CTRL_WMASK);
            wr(`ADDR_GEN_CTRL, d);
            wr(`ADDR_SELECTOR, r);
            wr(amap[i % 7], d ^ r);
            word_r <= 40'({$random(seed), $random(seed)});
            fire_r <= i[1:0];
            @(posedge ref_clk_in);
            fire_r <= 2'h0;
            if (i[sel[20]]) begin
                rw = ~word_r;
                lw = word_r;
            end
            for (int k = 0; k < 7; k++) rd(amap[k]);
            out_chk;
        end
        test_done;
    end
endmodule // tb
`default_nettype wire
